// ---- module_and_soft_interrupt_ctrl.sv ----
// Purpose: Gathers module and software interrupt events and posts a level to the core.
// Assumes: All event and bus inputs come from logic on the system clock.
// Notes:   Illegal core and external master accesses are caught here and raise level 7.
`include "intc_cfg.svh"
`default_nettype none

module module_and_soft_interrupt_ctrl
  import intc_pkg::*;
(
  input  wire logic        clk_sys_i,    // System clock, 25 MHz.
  input  wire logic        nrst_i,       // Synchronous reset, active low.
  input  wire logic [7:0]  reg_addr_i,   // Register byte address.
  input  wire logic [31:0] reg_wdata_i,  // Register write data.
  input  wire logic        reg_wr_i,     // Register write strobe.
  input  wire logic        reg_rd_i,     // Register read strobe.
  output logic      [31:0] reg_rdata_o,  // Read data, one cycle after the strobe.
  input  wire logic [30:0] hw_evt_i,     // Module event pulses.
  input  wire logic [43:0] hw_status_i,  // Module status bits, four per module.
  input  wire logic        core_as_i,    // Core address strobe.
  input  wire logic [23:0] core_addr_i,  // Core address.
  output logic             core_ack_o,   // Transfer acknowledge for illegal core access.
  output logic             core_berr_o,  // Bus error to core, always low.
  input  wire logic        ext_as_i,     // External master address strobe.
  input  wire logic [23:0] ext_addr_i,   // External master address.
  output logic             ext_ack_o,    // Transfer acknowledge for illegal external access.
  output logic      [2:0]  ipl_o,        // Interrupt level to the core.
  output logic             nmi_o         // Pulse on each rise to level 7.
);

  localparam int unsigned NM   = `ICTL_NUM_MOD;
  localparam int unsigned MW   = `ICTL_MOD_EVT_MAX;
  localparam int unsigned SW   = `ICTL_STAT_W;
  localparam int unsigned NS   = `ICTL_NUM_SWI;
  localparam int unsigned NR   = `ICTL_NUM_REGION;
  localparam int unsigned RW   = `ICTL_RGN_W;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////////////

  // Events per posting module, in register order.
  function automatic int unsigned evt_width(input int unsigned m);
    case (m)
      0:       evt_width = 5;   // video_output_module
      1:       evt_width = 2;   // graphics_engine_module
      2:       evt_width = 2;   // printer link
      3:       evt_width = 1;   // timer
      4:       evt_width = 3;   // general_dma_module
      5:       evt_width = 3;   // port_dma_module
      6:       evt_width = 11;  // parallel_host_port_module
      default: evt_width = 1;   // external interrupts 0 to 3
    endcase
  endfunction : evt_width

  function automatic int unsigned evt_base(input int unsigned m);
    int unsigned acc;
    acc = 0;
    for (int unsigned k = 0; k < m; k++) begin
      acc = acc + evt_width(k);
    end
    evt_base = acc;
  endfunction : evt_base

  function automatic level_t max_level(input level_t a, input level_t b);
    max_level = (a > b) ? a : b;
  endfunction : max_level

  function automatic acc_state_t acc_next(input acc_state_t s, input logic as, input logic hit);
    acc_state_t n;
    n = s;
    unique case (s)
      ACC_IDLE: begin
        if (as) begin
          n = hit ? ACC_LEGAL : ACC_ILLEGAL;
        end
      end
      ACC_LEGAL,
      ACC_ILLEGAL: begin
        if (!as) begin
          n = ACC_IDLE;
        end
      end
      default: begin
        n = ACC_IDLE;
      end
    endcase
    acc_next = n;
  endfunction : acc_next

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  ////////////////////////////////////////////////////////////////////////////

  logic [5:0] word_w;
  logic       is_mod_w;
  logic       is_swi_w;
  logic       is_rgn_w;
  logic [3:0] mod_idx_w;
  logic [1:0] rgn_idx_w;
  logic       wr_swi_w;

  assign word_w    = reg_addr_i[7:2];
  assign is_mod_w  = (reg_addr_i[1:0] == 2'h0) &&
                     (reg_addr_i >= `ICTL_OFF_MOD0) &&
                     (reg_addr_i < 8'(`ICTL_OFF_MOD0 + 4 * NM));
  assign is_swi_w  = (reg_addr_i == `ICTL_OFF_SWI);
  assign is_rgn_w  = (reg_addr_i[1:0] == 2'h0) &&
                     (reg_addr_i >= `ICTL_OFF_REGION0) &&
                     (reg_addr_i < 8'(`ICTL_OFF_REGION0 + 4 * NR));
  assign mod_idx_w = 4'(word_w - 6'(`ICTL_OFF_MOD0 >> 2));
  assign rgn_idx_w = 2'(word_w - 6'(`ICTL_OFF_REGION0 >> 2));
  assign wr_swi_w  = reg_wr_i && is_swi_w;

  ////////////////////////////////////////////////////////////////////////////
  // Module event groups
  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] mod_rd_w  [NM];
  level_t      mod_lvl_w [NM];

  for (genvar m = 0; m < NM; m++) begin : g_mod
    localparam int unsigned W    = evt_width(m);
    localparam int unsigned B    = evt_base(m);
    localparam logic [MW-1:0] VM = MW'((1 << W) - 1);

    logic          wr_w;
    logic [W-1:0]  clr_w;
    logic [W-1:0]  flag_w;
    logic [W-1:0]  req_w;
    logic [MW-1:0] en_q;
    level_t        lvl_q;

    assign wr_w  = reg_wr_i && is_mod_w && (mod_idx_w == 4'(m));
    assign clr_w = wr_w ? reg_wdata_i[`ICTL_MOD_EVT_LSB +: W] : '0;

    event_group #(
      .N (W)
    ) u_grp (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .set_i     (hw_evt_i[B +: W]),
      .clr_i     (clr_w),
      .en_i      (en_q[W-1:0]),
      .flag_o    (flag_w),
      .req_o     (req_w)
    );

    always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
        en_q  <= `ICTL_MOD_EN_RST;
        lvl_q <= `ICTL_MOD_LVL_RST;
      end else if (wr_w) begin
        en_q  <= reg_wdata_i[`ICTL_MOD_EN_LSB +: MW] & VM;
        lvl_q <= reg_wdata_i[`ICTL_MOD_LVL_LSB +: 3];
      end
    end

    // Level zero leaves the module silent even with enabled events pending.
    assign mod_lvl_w[m] = (|req_w) ? lvl_q : `ICTL_LEVEL_NONE;

    // Status bits are only read back; they feed no request.
    assign mod_rd_w[m] = {1'b0, lvl_q, 1'b0, en_q,
                          hw_status_i[m*SW +: SW], 1'b0, MW'(flag_w)};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software interrupts and illegal address flags
  ////////////////////////////////////////////////////////////////////////////

  logic [NS-1:0] sw_en_q;
  logic [NS-1:0] sw_set_w;
  logic [NS-1:0] sw_clr_w;
  logic [NS-1:0] sw_flag_w;
  logic [NS-1:0] sw_req_w;
  logic [1:0]    err_set_w;
  logic [1:0]    err_clr_w;
  logic [1:0]    err_flag_w;
  logic [1:0]    err_req_w;
  logic          core_bad_w;
  logic          ext_bad_w;

  // Setting a pending bit again just holds it set.
  assign sw_set_w  = wr_swi_w ? reg_wdata_i[`ICTL_SWI_SET_LSB +: NS] : '0;
  assign sw_clr_w  = wr_swi_w ? reg_wdata_i[`ICTL_SWI_EVT_LSB +: NS] : '0;

  event_group #(
    .N (NS)
  ) u_swi (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .set_i     (sw_set_w),
    .clr_i     (sw_clr_w),
    .en_i      (sw_en_q),
    .flag_o    (sw_flag_w),
    .req_o     (sw_req_w)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sw_en_q <= `ICTL_SWI_EN_RST;
    end else if (wr_swi_w) begin
      sw_en_q <= reg_wdata_i[`ICTL_SWI_EN_LSB +: NS];
    end
  end

  // Bit 0 is the core flag, bit 1 the external master flag; neither can be masked.
  assign err_set_w = {ext_bad_w, core_bad_w};
  assign err_clr_w = wr_swi_w ? {reg_wdata_i[`ICTL_SWI_EXT_ILL_BIT], reg_wdata_i[`ICTL_SWI_CORE_ILL_BIT]}
                              : 2'h0;

  event_group #(
    .N (2)
  ) u_err (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .set_i     (err_set_w),
    .clr_i     (err_clr_w),
    .en_i      (2'h3),
    .flag_o    (err_flag_w),
    .req_o     (err_req_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address regions and illegal access tracking
  ////////////////////////////////////////////////////////////////////////////

  logic [NR*RW-1:0] rgn_base_q;
  logic [NR*RW-1:0] rgn_mask_q;
  logic [NR-1:0]    rgn_en_q;
  logic             core_hit_w;
  logic             ext_hit_w;
  acc_state_t       core_st_q;
  acc_state_t       core_st_d;
  acc_state_t       ext_st_q;
  acc_state_t       ext_st_d;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rgn_base_q <= '0;
      rgn_mask_q <= '0;
      rgn_en_q   <= '0;
    end else if (reg_wr_i && is_rgn_w) begin
      rgn_base_q[rgn_idx_w*RW +: RW] <= reg_wdata_i[`ICTL_RGN_BASE_LSB +: RW];
      rgn_mask_q[rgn_idx_w*RW +: RW] <= reg_wdata_i[`ICTL_RGN_MASK_LSB +: RW];
      rgn_en_q[rgn_idx_w]            <= reg_wdata_i[`ICTL_RGN_EN_BIT];
    end
  end

  region_decode #(
    .NREG (NR),
    .RW   (RW)
  ) u_core_dec (
    .addr_i (core_addr_i),
    .base_i (rgn_base_q),
    .mask_i (rgn_mask_q),
    .en_i   (rgn_en_q),
    .hit_o  (core_hit_w)
  );

  region_decode #(
    .NREG (NR),
    .RW   (RW)
  ) u_ext_dec (
    .addr_i (ext_addr_i),
    .base_i (rgn_base_q),
    .mask_i (rgn_mask_q),
    .en_i   (rgn_en_q),
    .hit_o  (ext_hit_w)
  );

  // The flag is set once per access, on the first cycle of the strobe.
  assign core_st_d  = acc_next(core_st_q, core_as_i, core_hit_w);
  assign ext_st_d   = acc_next(ext_st_q, ext_as_i, ext_hit_w);
  assign core_bad_w = (core_st_q == ACC_IDLE) && (core_st_d == ACC_ILLEGAL);
  assign ext_bad_w  = (ext_st_q == ACC_IDLE) && (ext_st_d == ACC_ILLEGAL);

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      core_st_q <= ACC_IDLE;
      ext_st_q  <= ACC_IDLE;
    end else begin
      core_st_q <= core_st_d;
      ext_st_q  <= ext_st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level resolution
  ////////////////////////////////////////////////////////////////////////////

  level_t lvl_w;

  always_comb begin
    lvl_w = `ICTL_LEVEL_NONE;
    for (int unsigned m = 0; m < NM; m++) begin
      lvl_w = max_level(lvl_w, mod_lvl_w[m]);
    end
    for (int unsigned b = 0; b < NS; b++) begin
      if (sw_req_w[b]) begin
        lvl_w = max_level(lvl_w, 3'(b + 1));
      end
    end
    if (|err_req_w) begin
      lvl_w = `ICTL_LEVEL_NMI;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and outputs
  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] swi_rd_w;
  logic [31:0] rgn_rd_w;
  logic [31:0] rd_word_w;
  logic [31:0] rdata_q;
  level_t      ipl_q;
  logic        nmi_q;
  logic        core_ack_q;
  logic        ext_ack_q;
  logic        core_berr_q;

  // The set field is write-only and reads back as zero.
  assign swi_rd_w  = {1'b0, sw_en_q, 15'h0000, err_flag_w, sw_flag_w};
  assign rgn_rd_w  = {rgn_en_q[rgn_idx_w], 3'h0, rgn_mask_q[rgn_idx_w*RW +: RW],
                      4'h0, rgn_base_q[rgn_idx_w*RW +: RW]};
  assign rd_word_w = is_mod_w ? mod_rd_w[mod_idx_w] :
                     is_swi_w ? swi_rd_w :
                     is_rgn_w ? rgn_rd_w : 32'h00000000;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rdata_q     <= 32'h00000000;
      ipl_q       <= `ICTL_LEVEL_NONE;
      nmi_q       <= 1'b0;
      core_ack_q  <= 1'b0;
      ext_ack_q   <= 1'b0;
      core_berr_q <= 1'b0;
    end else begin
      rdata_q     <= reg_rd_i ? rd_word_w : 32'h00000000;
      ipl_q       <= lvl_w;
      nmi_q       <= (lvl_w == `ICTL_LEVEL_NMI) && (ipl_q != `ICTL_LEVEL_NMI);
      core_ack_q  <= (core_st_d == ACC_ILLEGAL);
      ext_ack_q   <= (ext_st_d == ACC_ILLEGAL);
      core_berr_q <= 1'b0;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign ipl_o       = ipl_q;
  assign nmi_o       = nmi_q;
  assign core_ack_o  = core_ack_q;
  assign ext_ack_o   = ext_ack_q;
  assign core_berr_o = core_berr_q;

endmodule : module_and_soft_interrupt_ctrl

`default_nettype wire

// ---- intc_cfg.svh ----
// Purpose: Register map, field positions and reset values of the interrupt controller.
// Assumes: 32-bit register port with byte addresses, one word per register.
// Notes:   Module i event register sits at MOD0 plus four times i.
`ifndef INTC_CFG_SVH
`define INTC_CFG_SVH

`define ICTL_NUM_MOD      11
`define ICTL_NUM_HW_EVT   31
`define ICTL_MOD_EVT_MAX  11
`define ICTL_STAT_W       4
`define ICTL_NUM_SWI      7
`define ICTL_NUM_REGION   4
`define ICTL_RGN_W        12

`define ICTL_OFF_MOD0     8'h00
`define ICTL_OFF_SWI      8'h2C
`define ICTL_OFF_REGION0  8'h30

`define ICTL_MOD_EVT_LSB  0
`define ICTL_MOD_STAT_LSB 12
`define ICTL_MOD_EN_LSB   16
`define ICTL_MOD_LVL_LSB  28

`define ICTL_SWI_EVT_LSB  0
`define ICTL_SWI_CORE_ILL_BIT 7
`define ICTL_SWI_EXT_ILL_BIT  8
`define ICTL_SWI_SET_LSB  16
`define ICTL_SWI_EN_LSB   24

`define ICTL_RGN_BASE_LSB 0
`define ICTL_RGN_MASK_LSB 16
`define ICTL_RGN_EN_BIT   31

`define ICTL_MOD_EN_RST   11'h000
`define ICTL_MOD_LVL_RST  3'h0
`define ICTL_SWI_EN_RST   7'h7F
`define ICTL_RGN_RST      12'h000
`define ICTL_LEVEL_NMI    3'h7
`define ICTL_LEVEL_NONE   3'h0

`endif

// ---- intc_pkg.sv ----
// Purpose: Types shared by the interrupt controller files.
// Assumes: Nothing beyond the configuration header.
// Notes:   Constants live in the header; this package holds types only.
`default_nettype none

package intc_pkg;

  typedef logic [2:0] level_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_LEGAL,
    ACC_ILLEGAL
  } acc_state_t;

endpackage : intc_pkg

`default_nettype wire

// ---- event_group.sv ----
// Purpose: Sticky event flags with write-one-to-clear and an enable mask.
// Assumes: Set and clear inputs are one-cycle pulses on the system clock.
// Notes:   A set that meets a clear is parked one cycle so the request drops and returns.
`default_nettype none

module event_group #(
  parameter int unsigned N = 1
) (
  input  wire logic         clk_sys_i,  // System clock.
  input  wire logic         nrst_i,     // Synchronous reset, active low.
  input  wire logic [N-1:0] set_i,      // Event pulses.
  input  wire logic [N-1:0] clr_i,      // Write-one-to-clear pulses.
  input  wire logic [N-1:0] en_i,       // Enable mask.
  output logic      [N-1:0] flag_o,     // Captured events.
  output logic      [N-1:0] req_o       // Enabled pending events.
);

  logic [N-1:0] flag_q;
  logic [N-1:0] flag_d;
  logic [N-1:0] park_q;
  logic [N-1:0] park_d;

  // Set wins over clear, but only after a one-cycle gap, so the core sees a fresh edge.
  assign park_d = set_i & clr_i;
  assign flag_d = (flag_q & ~clr_i) | (set_i & ~clr_i) | park_q;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      flag_q <= '0;
      park_q <= '0;
    end else begin
      flag_q <= flag_d;
      park_q <= park_d;
    end
  end

  assign flag_o = flag_q;
  assign req_o  = flag_q & en_i;

endmodule : event_group

`default_nettype wire

// ---- region_decode.sv ----
// Purpose: Matches an address against the programmed module regions.
// Assumes: Each region compares the upper address bits under a mask.
// Notes:   A region with its enable clear never matches.
`default_nettype none

module region_decode #(
  parameter int unsigned NREG = 4,
  parameter int unsigned RW   = 12
) (
  input  wire logic [23:0]        addr_i,   // Address under test.
  input  wire logic [NREG*RW-1:0] base_i,   // Region bases, packed.
  input  wire logic [NREG*RW-1:0] mask_i,   // Region compare masks, packed.
  input  wire logic [NREG-1:0]    en_i,     // Region enables.
  output logic                    hit_o     // Some region matches.
);

  logic [RW-1:0]   top_w;
  logic [NREG-1:0] match_w;

  assign top_w = addr_i[23 -: RW];

  for (genvar r = 0; r < NREG; r++) begin : g_rgn
    assign match_w[r] = en_i[r] &&
                        ((top_w & mask_i[r*RW +: RW]) == (base_i[r*RW +: RW] & mask_i[r*RW +: RW]));
  end

  assign hit_o = |match_w;

endmodule : region_decode

`default_nettype wire

// ---- access_master_model.sv ----
// Purpose: Bus master that presents one address phase to the block.
// Assumes: The block acknowledges only illegal accesses.
// Notes:   Legal accesses are answered elsewhere, so the model gives up after four edges.
`default_nettype none
//////////////////////////////////////////////////
module access_master_model (
  input  wire logic        clk_sys_i, // System clock.
  input  wire logic        nrst_i,    // Synchronous reset, active low.
  input  wire logic        start_i,   // Begin one access.
  input  wire logic [23:0] addr_i,    // Address to present.
  input  wire logic        ack_i,     // Acknowledge from the block.
  output logic             as_o,      // Address strobe.
  output logic      [23:0] addr_o,    // Address bus.
  output logic             got_o      // Last access was acknowledged.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q;
  // A released bus shows the inverse address, never the stale one.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      as_o   <= 1'h0;
      addr_o <= 24'h000000;
      got_o  <= 1'h0;
      wait_q <= 2'h0;
    end else if (start_i && !as_o) begin
      as_o   <= 1'h1;
      addr_o <= addr_i;
      got_o  <= 1'h0;
      wait_q <= 2'h0;
    end else if (as_o) begin
      wait_q <= wait_q + 2'h1;
      if (ack_i || wait_q == 2'h3) begin
        as_o   <= 1'h0;
        addr_o <= ~addr_o;
        got_o  <= ack_i;
      end
    end
  end
endmodule : access_master_model
`default_nettype wire

// ---- intc_checker.sv ----
// Purpose: Port-level assertions for the interrupt controller.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Level figures per source are judged by the bench.
`default_nettype none
//////////////////////////////////////////////////
module intc_checker (
  input wire logic        clk_sys_i,   // System clock.
  input wire logic        nrst_i,      // Reset, active low.
  input wire logic [30:0] hw_evt_i,    // Module event pulses.
  input wire logic        reg_wr_i,    // Register write strobe.
  input wire logic        core_as_i,   // Core address strobe.
  input wire logic        ext_as_i,    // External address strobe.
  input wire logic        core_ack_o,  // Core acknowledge.
  input wire logic        core_berr_o, // Core bus error.
  input wire logic        ext_ack_o,   // External acknowledge.
  input wire logic [2:0]  ipl_o,       // Level to core.
  input wire logic        nmi_o        // Level 7 pulse.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic [2:0] act_q;
  // A parked set returns three edges after its cause, so three stages are kept.
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      act_q <= 3'h0;
    end else begin
      act_q <= {act_q[1:0], (|hw_evt_i) | reg_wr_i | core_as_i | ext_as_i};
    end
  end
  property p_no_berr; !core_berr_o; endproperty
  a_no_berr: assert property (p_no_berr) else $error("bus error to core");
  property p_nmi_rise; nmi_o == (ipl_o == 3'h7 && $past(ipl_o) != 3'h7); endproperty
  a_nmi_rise: assert property (p_nmi_rise) else $error("nmi not tied to rise to 7");
  property p_nmi_pulse; nmi_o |=> !nmi_o; endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi longer than one cycle");
  property p_cack_cause; !core_as_i |=> !core_ack_o; endproperty
  a_cack_cause: assert property (p_cack_cause) else $error("core ack without strobe");
  property p_cack_lvl; $rose(core_ack_o) |=> ipl_o == 3'h7; endproperty
  a_cack_lvl: assert property (p_cack_lvl) else $error("core illegal access not level 7");
  property p_eack_lvl; $rose(ext_ack_o) |=> ipl_o == 3'h7; endproperty
  a_eack_lvl: assert property (p_eack_lvl) else $error("external illegal access not level 7");
  property p_eack_hold; ext_ack_o && ext_as_i |=> ext_ack_o; endproperty
  a_eack_hold: assert property (p_eack_hold) else $error("external ack dropped early");
  property p_ipl_cause; ipl_o > $past(ipl_o) |-> act_q != 3'h0; endproperty
  a_ipl_cause: assert property (p_ipl_cause) else $error("level rose without cause");
  c_nmi: cover property (nmi_o);
  c_ext: cover property ($rose(ext_ack_o));
  c_race: cover property (ipl_o == 3'h5 ##1 ipl_o == 3'h0 ##1 ipl_o == 3'h5);
endmodule : intc_checker

bind module_and_soft_interrupt_ctrl intc_checker i_intc_checker (.clk_sys_i, .nrst_i, .hw_evt_i, .reg_wr_i,
  .core_as_i, .ext_as_i, .core_ack_o, .core_berr_o, .ext_ack_o, .ipl_o, .nmi_o);
`default_nettype wire

// ---- tb_module_and_soft_interrupt_ctrl.sv ----
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Read data stands only in the cycle after the strobe.
// Notes:   Regions start disabled, so every access is illegal until mapped.
`default_nettype none
//////////////////////////////////////////////////
module tb_module_and_soft_interrupt_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i   = 1'h0;
  logic        nrst_i      = 1'h0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i    = 1'h0;
  logic        reg_rd_i    = 1'h0;
  logic [30:0] hw_evt_i    = 31'h0;
  logic [43:0] hw_status_i = 44'h0000000A000;
  logic [1:0]  st          = 2'h0;
  logic [23:0] adr         = 24'h0;
  logic [31:0] reg_rdata_o;
  logic [23:0] core_addr_i, ext_addr_i;
  logic [2:0]  ipl_o;
  logic        core_as_i, ext_as_i, core_ack_o, core_berr_o, ext_ack_o, nmi_o, c_got, e_got;
  int          fails = 0;
  int          samples_checked = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  module_and_soft_interrupt_ctrl i_module_and_soft_interrupt_ctrl (.clk_sys_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .hw_evt_i, .hw_status_i, .core_as_i, .core_addr_i,
    .core_ack_o, .core_berr_o, .ext_as_i, .ext_addr_i, .ext_ack_o, .ipl_o, .nmi_o);
  access_master_model i_core_master (.clk_sys_i, .nrst_i, .start_i(st[0]), .addr_i(adr),
    .ack_i(core_ack_o), .as_o(core_as_i), .addr_o(core_addr_i), .got_o(c_got));
  access_master_model i_ext_master (.clk_sys_i, .nrst_i, .start_i(st[1]), .addr_i(adr),
    .ack_i(ext_ack_o), .as_o(ext_as_i), .addr_o(ext_addr_i), .got_o(e_got));
  //////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'h1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'h1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'h0;
    #1 chk(reg_rdata_o, exp);
  endtask : rd
  // The level lands one edge after the edge that took the cause.
  task automatic lv(input logic [2:0] e);
    @(posedge clk_sys_i);
    #1 chk({29'h0, ipl_o}, {29'h0, e});
  endtask : lv
  task automatic ev(input int n);
    @(posedge clk_sys_i);
    hw_evt_i <= 31'h1 << n;
    @(posedge clk_sys_i);
    hw_evt_i <= 31'h0;
  endtask : ev
  task automatic acc(input logic ext, input logic [23:0] a, input logic exp);
    int i;
    @(posedge clk_sys_i);
    st  <= {ext, !ext};
    adr <= a;
    @(posedge clk_sys_i);
    st <= 2'h0;
    for (i = 0; i < 10; i++) begin
      @(posedge clk_sys_i);
      #1 if (!core_as_i && !ext_as_i) break;
    end
    if (i == 10) begin
      fails++;
      end_of_test;
    end
    chk({31'h0, ext ? e_got : c_got}, {31'h0, exp});
  endtask : acc
  //////////////////////////////////////////////////
  task automatic t_hw;
    rd(8'h2C, 32'h7F000000);
    rd(8'h40, 32'h00000000);
    wr(8'h0C, 32'h50000000);
    wr(8'h0C, 32'h50010000);
    lv(3'h0);
    ev(9);
    lv(3'h5);
    rd(8'h0C, 32'h5001A001);
    wr(8'h0C, 32'h50010000);
    lv(3'h5);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'h1;
    reg_addr_i  <= 8'h0C;
    reg_wdata_i <= 32'h50010001;
    hw_evt_i    <= 31'h00000200;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
    hw_evt_i <= 31'h0;
    lv(3'h0);
    lv(3'h5);
    wr(8'h0C, 32'h00010001);
    ev(9);
    lv(3'h0);
    wr(8'h0C, 32'h50010001);
  endtask : t_hw
  task automatic t_mask;
    wr(8'h10, 32'h30000000);
    ev(11);
    lv(3'h0);
    rd(8'h10, 32'h30000002);
    wr(8'h10, 32'h30020000);
    lv(3'h3);
    ev(9);
    lv(3'h5);
    wr(8'h0C, 32'h50010001);
    lv(3'h3);
    wr(8'h10, 32'h30020002);
    lv(3'h0);
  endtask : t_mask
  task automatic t_sw;
    for (int n = 0; n < 7; n++) begin
      wr(8'h2C, 32'h7F000000 | (32'h1 << (16 + n)));
      lv(3'(n + 1));
      chk({31'h0, nmi_o}, {31'h0, n == 6});
    end
    wr(8'h2C, 32'h7F7F0000);
    lv(3'h7);
    rd(8'h2C, 32'h7F00007F);
    for (int n = 6; n >= 0; n--) begin
      wr(8'h2C, 32'h7F000000 | (32'h1 << n));
      lv(3'(n));
    end
    wr(8'h2C, 32'h7E010000);
    lv(3'h0);
    rd(8'h2C, 32'h7E000001);
    wr(8'h2C, 32'h7F000001);
  endtask : t_sw
  task automatic t_illegal;
    acc(1'h0, 24'h123456, 1'h1);
    lv(3'h7);
    rd(8'h2C, 32'h7F000080);
    wr(8'h2C, 32'h7F000080);
    lv(3'h0);
    wr(8'h30, 32'h8FFF0123);
    acc(1'h0, 24'h123456, 1'h0);
    acc(1'h1, 24'h123ABC, 1'h0);
    lv(3'h0);
    acc(1'h1, 24'h800000, 1'h1);
    lv(3'h7);
    rd(8'h2C, 32'h7F000100);
    wr(8'h2C, 32'h7F000100);
    lv(3'h0);
  endtask : t_illegal
  initial begin
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'h1;
    t_hw;
    t_mask;
    t_sw;
    t_illegal;
    end_of_test;
  end
endmodule : tb_module_and_soft_interrupt_ctrl
`default_nettype wire
